// >>> include/qdw_params.svh
// Constants for the quad converter serial write port.
`ifndef QDW_PARAMS_SVH
`define QDW_PARAMS_SVH

// Serial word and channel layout.
`define QDW_WORD_W      16
`define QDW_CODE_W      10
`define QDW_NCH         4
`define QDW_SEL_LSB     14
`define QDW_MODE_LSB    12
`define QDW_DATA_LSB    2

// Fastest serial clock the host may use, in MHz.
`define QDW_SCLK_MAX_MHZ 40

// Register byte offsets.
`define QDW_OFF_CTRL    12'h000
`define QDW_OFF_STATUS  12'h004
`define QDW_OFF_LAST    12'h008
`define QDW_OFF_INJECT  12'h00c
`define QDW_OFF_COUNT   12'h010
`define QDW_OFF_CH0     12'h020

// Reset values.
`define QDW_CTRL_RST    1'b1
`define QDW_CODE_RST    10'h000

// Status field positions.
`define QDW_ST_PD       0
`define QDW_ST_TERM     1
`define QDW_ST_BUSY     3
`define QDW_ST_INJ      4
`define QDW_ST_MODE     6

`endif

// >>> include/qdw_pkg.sv
// Types shared by the serial write port modules.
package qdw_pkg;

  typedef enum logic [1:0] {
    qdw_mode_load = 2'b00,
    qdw_mode_one  = 2'b01,
    qdw_mode_all  = 2'b10,
    qdw_mode_pd   = 2'b11
  } qdw_mode_t;

  typedef enum logic [1:0] {
    qdw_term_hiz0 = 2'b00,
    qdw_term_low  = 2'b01,
    qdw_term_mid  = 2'b10,
    qdw_term_hiz  = 2'b11
  } qdw_term_t;

  typedef enum logic [3:0] {
    qdw_reg_none   = 4'h0,
    qdw_reg_ctrl   = 4'h1,
    qdw_reg_status = 4'h2,
    qdw_reg_last   = 4'h3,
    qdw_reg_inject = 4'h4,
    qdw_reg_count  = 4'h5,
    qdw_reg_chan   = 4'h6
  } qdw_reg_t;

endpackage

// >>> verilog/qdw_shift.sv
// Serial shift register running on the host's serial clock.
`timescale 1ns/10ps
`include "qdw_params.svh"
module qdw_shift #(
  parameter int WORD_W = `QDW_WORD_W
) (
  // Link pins.
  input  wire logic              sclk,
  input  wire logic              sync_n,
  input  wire logic              din,
  // Reset from the bus side.
  input  wire logic              hresetn,
  // Completed word.
  output logic [WORD_W-1:0]      word,
  output logic                   done_tgl
);

  localparam int CNT_W = $clog2(WORD_W + 1);
  localparam logic [CNT_W-1:0] FULL = CNT_W'(WORD_W);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(WORD_W - 1);

  logic [WORD_W-1:0] shreg;
  logic [CNT_W-1:0]  bit_cnt;

  // A high frame sync holds the counter cleared, so a frame that ends early
  // leaves nothing behind and the next frame starts from bit zero.
  always_ff @(negedge sclk or posedge sync_n) begin
    if (sync_n) begin
      bit_cnt <= '0;
      shreg   <= '0;
    end else if (bit_cnt != FULL) begin
      shreg   <= {shreg[WORD_W-2:0], din};
      bit_cnt <= bit_cnt + 1'b1;
    end
  end

  // The word and its toggle survive the frame's end; the toggle tells the
  // bus side that a new word stands.
  always_ff @(negedge sclk or negedge hresetn) begin
    if (!hresetn) begin
      word     <= '0;
      done_tgl <= 1'b0;
    end else if (!sync_n && bit_cnt == LAST) begin
      word     <= {shreg[WORD_W-2:0], din};
      done_tgl <= ~done_tgl;
    end
  end

endmodule

// >>> verilog/qdw_xfer.sv
// Moves a finished serial word into the bus clock domain by a toggle.
`timescale 1ns/10ps
`include "qdw_params.svh"
module qdw_xfer #(
  parameter int W = `QDW_WORD_W
) (
  // Bus clock and reset.
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Link side.
  input  wire logic         src_tgl,
  input  wire logic [W-1:0] src_word,
  // Bus side.
  output logic              strobe,
  output logic [W-1:0]      word
);

  logic [2:0] tgl_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tgl_q <= '0;
    end else begin
      tgl_q <= {tgl_q[1:0], src_tgl};
    end
  end

  // The word is written on the same link edge as the toggle and holds for many link edges after it is seen here.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strobe <= 1'b0;
      word   <= '0;
    end else begin
      strobe <= tgl_q[2] ^ tgl_q[1];
      if (tgl_q[2] ^ tgl_q[1]) begin
        word <= src_word;
      end
    end
  end

endmodule

// >>> verilog/qdw_top.sv
// Quad converter serial write port with a register view on the bus.
`timescale 1ns/10ps
`include "qdw_params.svh"
module qdw_top #(
  parameter int WORD_W   = `QDW_WORD_W,
  parameter int CODE_W   = `QDW_CODE_W,
  parameter int SEL_LSB  = `QDW_SEL_LSB,
  parameter int MODE_LSB = `QDW_MODE_LSB,
  parameter int DATA_LSB = `QDW_DATA_LSB
) (
  // Bus clock and reset.
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // Register bus.
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // Serial link.
  input  wire logic              sclk,
  input  wire logic              sync_n,
  input  wire logic              din,
  // Converter state.
  output logic [CODE_W-1:0]      ch0_code,
  output logic [CODE_W-1:0]      ch1_code,
  output logic [CODE_W-1:0]      ch2_code,
  output logic [CODE_W-1:0]      ch3_code,
  output logic                   power_down,
  output logic [1:0]             pd_term
);

  localparam int NCH = `QDW_NCH;

  // Link word and its arrival in the bus domain.
  logic [WORD_W-1:0] link_word;
  logic              link_tgl;
  logic              link_stb;
  logic [WORD_W-1:0] link_word_h;

  // Register state.
  logic              ctrl_enable;
  logic [WORD_W-1:0] inject_word;
  logic              inject_pend;
  logic [WORD_W-1:0] last_word;
  logic [1:0]        last_mode;
  logic [15:0]       word_cnt;
  logic [15:0]       frame_cnt;
  logic [1:0]        busy_sync;
  logic              busy_q;
  logic              frame_start;

  // Channel state.
  logic [CODE_W-1:0] holding [NCH];
  logic [CODE_W-1:0] active  [NCH];

  // Bus pipeline.
  logic              wr_pend;
  logic [11:0]       wr_addr;
  logic              take;
  logic [31:0]       rd_word;

  // Word being applied this cycle.
  logic              apply;
  logic              apply_link;
  logic [WORD_W-1:0] apply_word;
  logic [1:0]        apply_sel;
  qdw_pkg::qdw_mode_t apply_mode;
  logic [CODE_W-1:0] apply_data;

  qdw_shift #(
    .WORD_W   (WORD_W)
  ) u_shift (
    .sclk     (sclk),
    .sync_n   (sync_n),
    .din      (din),
    .hresetn  (hresetn),
    .word     (link_word),
    .done_tgl (link_tgl)
  );

  qdw_xfer #(
    .W        (WORD_W)
  ) u_xfer (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .src_tgl  (link_tgl),
    .src_word (link_word),
    .strobe   (link_stb),
    .word     (link_word_h)
  );

  // Register decode shared by the read and the write paths.
  function automatic qdw_pkg::qdw_reg_t reg_of(input logic [11:0] a);
    if (a == `QDW_OFF_CTRL) begin
      reg_of = qdw_pkg::qdw_reg_ctrl;
    end else if (a == `QDW_OFF_STATUS) begin
      reg_of = qdw_pkg::qdw_reg_status;
    end else if (a == `QDW_OFF_LAST) begin
      reg_of = qdw_pkg::qdw_reg_last;
    end else if (a == `QDW_OFF_INJECT) begin
      reg_of = qdw_pkg::qdw_reg_inject;
    end else if (a == `QDW_OFF_COUNT) begin
      reg_of = qdw_pkg::qdw_reg_count;
    end else if (a[11:4] == 8'(`QDW_OFF_CH0 >> 4) && a[1:0] == 2'b00) begin
      reg_of = qdw_pkg::qdw_reg_chan;
    end else begin
      reg_of = qdw_pkg::qdw_reg_none;
    end
  endfunction

  // Field extraction from a received or injected word.
  function automatic logic [CODE_W-1:0] data_of(input logic [WORD_W-1:0] w);
    data_of = w[DATA_LSB +: CODE_W];
  endfunction

  // The link word takes precedence; an injected word waits one cycle so
  // neither is lost when they meet.
  always_comb begin
    apply_link = link_stb && ctrl_enable;
    apply      = apply_link || inject_pend;
    apply_word = apply_link ? link_word_h : inject_word;
    apply_sel  = apply_word[SEL_LSB +: 2];
    apply_mode = qdw_pkg::qdw_mode_t'(apply_word[MODE_LSB +: 2]);
    apply_data = data_of(apply_word);
  end

  // Frame activity brought into the bus domain for status and counting.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_sync <= 2'b00;
      busy_q    <= 1'b0;
    end else begin
      busy_sync <= {busy_sync[0], ~sync_n};
      busy_q    <= busy_sync[1];
    end
  end

  // A frame starts where the synchronised frame sync first reads low.
  assign frame_start = busy_sync[1] && !busy_q;

  // Holding registers take every data word except a power-down word.
  // They are what a later joint update copies to the outputs.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NCH; i++) begin
        holding[i] <= `QDW_CODE_RST;
      end
    end else if (apply && apply_mode != qdw_pkg::qdw_mode_pd) begin
      holding[apply_sel] <= apply_data;
    end
  end

  // Each channel's active code starts at zero and moves only on an
  // accepted word that selects it or updates all channels together.
  for (genvar g = 0; g < NCH; g++) begin : g_chan
    logic sel_hit;

    assign sel_hit = apply_sel == 2'(g);

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        active[g] <= `QDW_CODE_RST;
      end else if (apply) begin
        case (apply_mode)
          qdw_pkg::qdw_mode_one: begin
            if (sel_hit) begin
              active[g] <= apply_data;
            end
          end
          qdw_pkg::qdw_mode_all: begin
            active[g] <= sel_hit ? apply_data : holding[g];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // A power-down word keeps the codes; any updating word wakes the outputs.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_down <= 1'b0;
    end else if (apply && apply_mode == qdw_pkg::qdw_mode_pd) begin
      power_down <= 1'b1;
    end else if (apply && apply_mode != qdw_pkg::qdw_mode_load) begin
      power_down <= 1'b0;
    end
  end

  // The termination of the last power-down word stays until the next one.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pd_term <= 2'b00;
    end else if (apply && apply_mode == qdw_pkg::qdw_mode_pd) begin
      pd_term <= apply_sel;
    end
  end

  // Record of the last word and running counts.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_word <= '0;
      last_mode <= 2'b00;
    end else if (apply) begin
      last_word <= apply_word;
      last_mode <= apply_mode;
    end
  end

  // Words accepted from the link; injected words are not counted.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      word_cnt <= 16'h0000;
    end else if (apply_link) begin
      word_cnt <= word_cnt + 16'h0001;
    end
  end

  // Frames started minus words accepted shows aborted or ignored frames.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_cnt <= 16'h0000;
    end else if (frame_start) begin
      frame_cnt <= frame_cnt + 16'h0001;
    end
  end

  // Bus address phase: zero wait states, so every valid phase is taken.
  assign take = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
    end else if (hready) begin
      wr_pend <= take && hwrite;
      wr_addr <= haddr[11:0];
    end
  end

  // Control register: the enable gates words arriving from the link.
  // Clearing it drops link words but their frames are still counted.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_enable <= `QDW_CTRL_RST;
    end else if (wr_pend && reg_of(wr_addr) == qdw_pkg::qdw_reg_ctrl) begin
      ctrl_enable <= hwdata[0];
    end
  end

  // Injection register lets software apply a word as if it came serially.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      inject_word <= '0;
      inject_pend <= 1'b0;
    end else if (wr_pend && reg_of(wr_addr) == qdw_pkg::qdw_reg_inject) begin
      inject_word <= hwdata[WORD_W-1:0];
      inject_pend <= 1'b1;
    end else if (!apply_link) begin
      inject_pend <= 1'b0;
    end
  end

  // Read data is fetched at the address phase and stands in the data phase.
  // Fetching early keeps the bus at zero wait states, at the cost of
  // returning the value as it stood at the address edge.
  always_comb begin
    rd_word = 32'h0000_0000;
    if (take && !hwrite) begin
      case (reg_of(haddr[11:0]))
        qdw_pkg::qdw_reg_ctrl: begin
          rd_word = {31'h0000_0000, ctrl_enable};
        end
        qdw_pkg::qdw_reg_status: begin
          rd_word = {24'h00_0000, last_mode, 1'b0, inject_pend, busy_q,
                     pd_term, power_down};
        end
        qdw_pkg::qdw_reg_last: begin
          rd_word = {{(32 - WORD_W){1'b0}}, last_word};
        end
        qdw_pkg::qdw_reg_inject: begin
          rd_word = {{(32 - WORD_W){1'b0}}, inject_word};
        end
        qdw_pkg::qdw_reg_count: begin
          rd_word = {frame_cnt, word_cnt};
        end
        qdw_pkg::qdw_reg_chan: begin
          rd_word = {{(32 - CODE_W){1'b0}}, active[haddr[3:2]]};
        end
        default: begin
          rd_word = 32'h0000_0000;
        end
      endcase
    end
  end

  // Outside a read data phase the bus sees zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else begin
      hrdata <= rd_word;
    end
  end

  // Every transfer completes at once with an OKAY response.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign ch0_code = active[0];
  assign ch1_code = active[1];
  assign ch2_code = active[2];
  assign ch3_code = active[3];

endmodule

// >>> bench/qdw_asserts.sv
// Checker of the serial write port outputs against its inputs.
`timescale 1ns/10ps
module qdw_asserts #(
  parameter int CODE_W = 10
) (
  // Bus side.
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic              hready,
  input wire logic [31:0]       hrdata,
  input wire logic              hreadyout,
  input wire logic              hresp,
  // Link and converter state.
  input wire logic              sync_n,
  input wire logic [CODE_W-1:0] ch0_code,
  input wire logic [CODE_W-1:0] ch1_code,
  input wire logic [CODE_W-1:0] ch2_code,
  input wire logic [CODE_W-1:0] ch3_code,
  input wire logic              power_down,
  input wire logic [1:0]        pd_term
);
  logic              rd_ph;
  logic              ch_hit;
  logic              st_hit;
  logic              un_hit;
  logic [CODE_W-1:0] exp_code;
  logic [2:0]        exp_st;
  logic [3:0]        quiet;
  wire logic         take = hsel & hready & htrans[1];
  wire logic [11:0]  a = haddr[11:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ph    <= 1'b0;
      ch_hit   <= 1'b0;
      st_hit   <= 1'b0;
      un_hit   <= 1'b0;
      exp_code <= '0;
      exp_st   <= 3'h0;
    end else begin
      rd_ph    <= take & ~hwrite;
      ch_hit   <= a[11:4] == 8'h02 && a[1:0] == 2'h0;
      st_hit   <= a == 12'h004;
      un_hit   <= a > 12'h013 && a[11:4] != 8'h02;
      exp_st   <= {pd_term, power_down};
      exp_code <= a[3] ? (a[2] ? ch3_code : ch2_code)
                       : (a[2] ? ch1_code : ch0_code);
    end
  end

  // Outputs may only move shortly after a frame or a bus write.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      quiet <= 4'h0;
    else if (!sync_n || (take && hwrite))
      quiet <= 4'h0;
    else if (quiet != 4'hf)
      quiet <= quiet + 4'h1;
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  rdata_zero_a: assert property (!rd_ph |-> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  ch_read_a: assert property (
    rd_ph && ch_hit |-> hrdata == 32'(exp_code))
    else $error("channel read differs from channel output");
  status_read_a: assert property (
    rd_ph && st_hit |-> hrdata[2:0] == exp_st)
    else $error("status read differs from power state");
  unmapped_read_a: assert property (rd_ph && un_hit |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  outs_quiet_a: assert property (quiet > 4'h8 |->
    $stable({ch0_code, ch1_code, ch2_code, ch3_code, power_down, pd_term}))
    else $error("outputs moved with no frame or bus write");
  pd_keeps_a: assert property ($rose(power_down) |->
    $stable({ch0_code, ch1_code, ch2_code, ch3_code}))
    else $error("power-down changed channel codes");
  term_hold_a: assert property ($changed(pd_term) |-> power_down)
    else $error("termination changed outside power-down");
endmodule

bind qdw_top qdw_asserts #(.CODE_W(CODE_W)) i_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .sync_n(sync_n),
  .ch0_code(ch0_code), .ch1_code(ch1_code), .ch2_code(ch2_code),
  .ch3_code(ch3_code), .power_down(power_down), .pd_term(pd_term)
);

// >>> bench/qdw_host.sv
// Behavioural host that drives frames on the serial link.
`timescale 1ns/10ps
module qdw_host (
  // Serial link.
  output logic sclk,
  output logic sync_n,
  output logic din
);
  initial begin
    // Scheduled late so the shift register sees the rise of frame sync.
    sclk <= 1'b1;
    sync_n <= 1'b1;
    din <= 1'b0;
  end

  // Sends the top n bits of w; fewer than 16 aborts the word.
  task automatic send(input logic [15:0] w, input int n);
    #7;
    sync_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      din = w[15-i];
      #15 sclk = 1'b0;
      #15 sclk = 1'b1;
    end
    #8 sync_n = 1'b1;
    // A released line shows no stale level, so flip it.
    din = ~din;
  endtask
endmodule

// >>> bench/qdw_tb.sv
// Self-checking bench for the quad converter serial write port.
`timescale 1ns/10ps
`include "qdw_params.svh"
module testbench;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout, hresp, sclk, sync_n, din, power_down;
  logic [9:0]  ch0, ch1, ch2, ch3;
  logic [1:0]  pd_term;
  int          errors = 0;
  int          n_compared = 0;

  always #10 hclk = ~hclk;

  qdw_top i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sclk(sclk), .sync_n(sync_n), .din(din),
    .ch0_code(ch0), .ch1_code(ch1), .ch2_code(ch2), .ch3_code(ch3),
    .power_down(power_down), .pd_term(pd_term)
  );
  qdw_host i_host (.sclk(sclk), .sync_n(sync_n), .din(din));

  task print_verdict;
    $display("compared %0d wrong %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 40) begin
      n++;
      @(posedge hclk);
    end
    if (hreadyout !== 1'b1) begin
      errors++;
      print_verdict();
    end
  endtask

  task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr <= {20'h0, a};
    hwrite <= w;
    hsel <= 1'b1;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  // The word reaches the outputs within five bus cycles of its last bit.
  task frame(input logic [1:0] sel, mode, input logic [9:0] c, input int n);
    i_host.send({sel, mode, c, 2'b00}, n);
    repeat (6) @(posedge hclk);
  endtask

  task t_one;
    chk({ch3, ch2, ch1, ch0}, 40'h0);
    chk(40'({pd_term, power_down}), 40'h0);
    frame(2'd1, qdw_pkg::qdw_mode_one, 10'h2a5, 16);
    chk({ch3, ch2, ch1, ch0}, {20'h0, 10'h2a5, 10'h0});
    $display("test single update done");
  endtask

  task t_all;
    frame(2'd0, qdw_pkg::qdw_mode_load, 10'h111, 16);
    chk({ch3, ch2, ch1, ch0}, {20'h0, 10'h2a5, 10'h0});
    frame(2'd2, qdw_pkg::qdw_mode_all, 10'h3ff, 16);
    chk({ch3, ch2, ch1, ch0}, {10'h0, 10'h3ff, 10'h2a5, 10'h111});
    $display("test joint update done");
  endtask

  task t_abort;
    frame(2'd3, qdw_pkg::qdw_mode_one, 10'h0aa, 15);
    chk({ch3, ch2, ch1, ch0}, {10'h0, 10'h3ff, 10'h2a5, 10'h111});
    frame(2'd3, qdw_pkg::qdw_mode_one, 10'h155, 16);
    chk({ch3, ch2, ch1, ch0}, {10'h155, 10'h3ff, 10'h2a5, 10'h111});
    $display("test abort done");
  endtask

  task t_pd;
    for (int t = 1; t < 4; t++) begin
      frame(2'(t), qdw_pkg::qdw_mode_pd, 10'h3c3, 16);
      chk(40'(power_down), 40'h1);
      chk(40'(pd_term), 40'(t));
      chk({ch3, ch2, ch1, ch0}, {10'h155, 10'h3ff, 10'h2a5, 10'h111});
    end
    frame(2'd0, qdw_pkg::qdw_mode_one, 10'h111, 16);
    chk(40'(power_down), 40'h0);
    $display("test power-down done");
  endtask

  task t_bus;
    ahb(1'b0, `QDW_OFF_CH0 + 12'h004, 32'h0);
    chk(40'(rd), 40'h2a5);
    ahb(1'b0, `QDW_OFF_STATUS, 32'h0);
    chk(40'(rd[2:0]), 40'h6);
    ahb(1'b1, 12'h030, 32'hffffffff);
    ahb(1'b0, 12'h030, 32'h0);
    chk(40'(rd), 40'h0);
    // Disabled words are dropped, so the frame must leave channel 1 alone.
    ahb(1'b1, `QDW_OFF_CTRL, 32'h0);
    frame(2'd1, qdw_pkg::qdw_mode_one, 10'h001, 16);
    chk(40'(ch1), 40'h2a5);
    ahb(1'b1, `QDW_OFF_CTRL, 32'h1);
    ahb(1'b1, `QDW_OFF_INJECT, 32'h000053c0);
    repeat (3) @(posedge hclk);
    chk({ch3, ch2, ch1, ch0}, {10'h155, 10'h3ff, 10'h0f0, 10'h111});
    ahb(1'b0, `QDW_OFF_LAST, 32'h0);
    chk(40'(rd), 40'h53c0);
    // Ten frames started; the aborted and the disabled one were not taken.
    ahb(1'b0, `QDW_OFF_COUNT, 32'h0);
    chk(40'(rd), 40'h000a0008);
    $display("test register bus done");
  endtask

  initial begin
    // A real falling edge, so the link-side flops see their reset too.
    hresetn <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_one();
    t_all();
    t_abort();
    t_pd();
    t_bus();
    print_verdict();
  end
endmodule
